//--- src/sbp_regs.vh
`ifndef SBP_REGS_VH
`define SBP_REGS_VH
`define SBP_WEDGES        54
`define SBP_TRACKS        1172
`define SBP_BURST_US      72
`define SBP_CLK_MHZ       100
`define SBP_BURST_CYC     (`SBP_BURST_US * `SBP_CLK_MHZ)
`define SBP_TRIAL_HALF    8'h7f
`define SBP_TRIAL_ALL     8'hff
`define SBP_GAIN_SHIFT    5
`define SBP_DRV_OUT_FULL  8'hff
`define SBP_DRV_ZERO      8'h80
`define SBP_DRV_IN_FULL   8'h00
`define SBP_BIT_LAST      3'h0
`define SBP_BIT_FIRST     3'h7
`endif

//--- src/sbp_sar.v
`timescale 1ns/1ns
`include "sbp_regs.vh"
// eight-step successive approximation register, active-low trial bits
module sbp_sar (
  input  wire       ref_clk,
  input  wire       reset_n,
  input  wire       start_n,
  input  wire       cmp_below,
  output reg  [7:0] trial_r,
  output reg  [7:0] result_r,
  output reg        busy_r,
  output reg        done_r
);
  reg [2:0] idx_r;

  // one trial bit resolved per clock
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      trial_r  <= `SBP_TRIAL_ALL;
      result_r <= 8'h00;
      busy_r   <= 1'b0;
      done_r   <= 1'b0;
      idx_r    <= `SBP_BIT_FIRST;
    end else if (!start_n) begin
      trial_r <= `SBP_TRIAL_HALF;
      busy_r  <= 1'b1;
      done_r  <= 1'b0;
      idx_r   <= `SBP_BIT_FIRST;
    end else if (busy_r) begin
      trial_r[idx_r] <= cmp_below;
      if (idx_r != `SBP_BIT_LAST) begin
        trial_r[idx_r - 3'h1] <= 1'b0;
        idx_r <= idx_r - 3'h1;
      end else begin
        busy_r   <= 1'b0;
        done_r   <= 1'b1;
        result_r <= ~{trial_r[7:1], cmp_below}; // inverted for processor
      end
    end
  end
endmodule

//--- src/sbp_servo.v
`timescale 1ns/1ns
`include "sbp_regs.vh"
// Operation
// - the servo surface has 54 wedges and every one of 1172 tracks repeats the same bursts.
// - each wedge alternates first and second bursts of 72 us each, the second sampled before the first.
// - the controller times the peak sample and clears the held peak before the next burst.
// - a conversion starts when the active-low kickoff goes low, pulsed at the end of each burst's peak window.
// - the held peak resolves to 8 bits in eight trials from the top bit down.
// - the first trial word after kickoff is half scale with only the top bit low.
// - a low decision means input above trial, the bit stays low, and it reads inverted.
// - error is 32(first-second)/sum on odd tracks and 32(second-first)/sum on even tracks.
// - the actuator code is all ones full outward, top bit alone zero, all zeros full inward.
// - the burst loop is used only for fine settling after coarse seek arrival.
module sbp_servo (
  input  wire       ref_clk,
  input  wire       reset_n,
  input  wire       fine_en,
  input  wire       odd_track,
  input  wire       cmp_below,
  output reg        peak_clear_r,
  output reg        peak_sample_r,
  output wire       start_n,
  output wire [7:0] trial_word,
  output reg  [7:0] burst_val_r,
  output reg  [7:0] pos_err_r,
  output reg        err_valid_r,
  output reg  [7:0] drive_code_r
);
  // one-hot sequencer states
  localparam [5:0] ST_IDLE  = 6'h01;
  localparam [5:0] ST_CLEAR = 6'h02;
  localparam [5:0] ST_HOLD  = 6'h04;
  localparam [5:0] ST_CONV  = 6'h08;
  localparam [5:0] ST_WAIT  = 6'h10;
  localparam [5:0] ST_CALC  = 6'h20;
  localparam [13:0] BURST_CYC = `SBP_BURST_CYC;
  localparam [5:0]  WEDGES    = `SBP_WEDGES;

  reg  [5:0]  state_r;
  reg  [13:0] cnt_r;
  reg         second_r;
  reg         kick_r;
  reg  [7:0]  last_b_r;
  reg  [7:0]  cur_a_r;
  reg  [5:0]  wedge_r;
  wire [7:0]  result;
  wire        busy;
  wire        done;
  // derived strobes and combinational selects
  wire        hold_end;
  wire        conv_end;
  wire        capture;
  wire        calc_go;
  reg  [7:0]  err_sel;
  reg  [5:0]  wedge_nxt;

  // signed 8-bit error = 32*(p-q)/(p+q)
  function [7:0] err_calc;
    input [7:0] p;
    input [7:0] q;
    reg signed [15:0] num;
    reg signed [15:0] den;
    reg signed [15:0] quo;
    begin
      num = ($signed({8'h00, p}) - $signed({8'h00, q})) <<< `SBP_GAIN_SHIFT;
      den = $signed({8'h00, p}) + $signed({8'h00, q});
      quo = (den == 16'sh0000) ? 16'sh0000 : num / den;
      err_calc = quo[7:0];
    end
  endfunction

  // offset-binary actuator code around zero current
  function [7:0] drive_of;
    input [7:0] err;
    begin
      drive_of = `SBP_DRV_ZERO ^ err;
    end
  endfunction

  assign start_n = ~kick_r;

  // end of one burst's peak window
  assign hold_end = (cnt_r == BURST_CYC - 14'h0001);
  // converter back to idle with a result
  assign conv_end = done && !busy;
  // result taken in the wait state only
  assign capture  = (state_r == ST_WAIT) && conv_end;
  // error update cycle
  assign calc_go  = (state_r == ST_CALC);

  // odd/even error sign
  // orientation follows track parity, A paired with latest B
  always @* begin
    if (odd_track) begin
      err_sel = err_calc(cur_a_r, last_b_r);
    end else begin
      err_sel = err_calc(last_b_r, cur_a_r);
    end
  end

  always @* begin
    if (wedge_r == WEDGES - 6'h01) begin
      wedge_nxt = 6'h00;
    end else begin
      wedge_nxt = wedge_r + 6'h01;
    end
  end

  // wedge position advances once per error update
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      wedge_r <= 6'h00;
    end else if (calc_go) begin
      wedge_r <= wedge_nxt;
    end
  end

  always @(posedge ref_clk) begin
    if (!reset_n) begin
      burst_val_r <= 8'h00;
      last_b_r    <= 8'h00;
      cur_a_r     <= 8'h00;
    end else if (capture) begin
      burst_val_r <= result;
      if (second_r) begin
        last_b_r <= result;
      end else begin
        cur_a_r <= result;
      end
    end
  end

  sbp_sar u_sar (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .start_n  (start_n),
    .cmp_below(cmp_below),
    .trial_r  (trial_word),
    .result_r (result),
    .busy_r   (busy),
    .done_r   (done)
  );

  // burst schedule and conversion sequencing
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      state_r       <= ST_IDLE;
      cnt_r         <= 14'h0000;
      second_r      <= 1'b0;
      kick_r        <= 1'b0;
      peak_clear_r  <= 1'b1;
      peak_sample_r <= 1'b0;
      pos_err_r     <= 8'h00;
      err_valid_r   <= 1'b0;
      drive_code_r  <= `SBP_DRV_ZERO;
    end else begin
      kick_r      <= 1'b0;
      err_valid_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          peak_clear_r  <= 1'b1;
          peak_sample_r <= 1'b0;
          // first burst after idle is a B burst
          second_r      <= 1'b1;
          cnt_r         <= 14'h0000;
          if (!fine_en) begin
            drive_code_r <= `SBP_DRV_ZERO;
          end else begin
            state_r <= ST_CLEAR;
          end
        end
        ST_CLEAR: begin
          peak_clear_r  <= 1'b0;
          peak_sample_r <= 1'b1;
          state_r       <= ST_HOLD;
        end
        ST_HOLD: begin
          if (hold_end) begin
            cnt_r         <= 14'h0000;
            peak_sample_r <= 1'b0;
            kick_r        <= 1'b1;
            state_r       <= ST_CONV;
          end else begin
            cnt_r <= cnt_r + 14'h0001;
          end
        end
        ST_CONV: begin
          state_r <= ST_WAIT;
        end
        ST_WAIT: begin
          if (conv_end) begin
            peak_clear_r <= 1'b1;
            if (second_r) begin
              state_r <= ST_CLEAR;
            end else begin
              state_r <= ST_CALC;
            end
            second_r <= ~second_r;
          end
        end
        ST_CALC: begin
          pos_err_r    <= err_sel;
          drive_code_r <= drive_of(err_sel);
          err_valid_r  <= 1'b1;
          state_r      <= fine_en ? ST_CLEAR : ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end
endmodule

//--- bench/sbp_servo_assertions.sv
`timescale 1ns/1ns
module sbp_chk (
  input logic ref_clk, reset_n, cmp_below, peak_clear_r, peak_sample_r, start_n, err_valid_r,
  input logic [7:0] trial_word, pos_err_r, drive_code_r
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  a_kick_width: assert property ($fell(start_n) |=> start_n) else $error("kick");
  a_half_scale: assert property ($fell(start_n) |=> trial_word == 8'h7f) else $error("half");
  a_top_kept: assert property ($fell(start_n) ##1 1 |=> trial_word == {$past(cmp_below), 7'h3f})
    else $error("step");
  a_clear_off: assert property ($fell(start_n) |-> !peak_clear_r) else $error("clear");
  a_clear_sample: assert property ($fell(peak_clear_r) |-> peak_sample_r) else $error("sample");
  a_err_pulse: assert property (err_valid_r |=> !err_valid_r) else $error("valid");
  a_drive_map: assert property (err_valid_r |-> drive_code_r == (pos_err_r ^ 8'h80)) else $error("code");
  a_reset_idle: assert property ($rose(reset_n) |-> drive_code_r == 8'h80 && start_n) else $error("idle");
  cover property ($fell(start_n));
  cover property (err_valid_r && drive_code_r[7]);
  cover property (err_valid_r && !drive_code_r[7]);
endmodule
bind sbp_servo sbp_chk sbp_chk_i (.ref_clk, .reset_n, .cmp_below, .peak_clear_r, .peak_sample_r, .start_n,
  .err_valid_r, .trial_word, .pos_err_r, .drive_code_r);

//--- bench/sbp_peak_model.sv
`timescale 1ns/1ns
module sbp_peak_model (
  input wire ref_clk, peak_clear_r, peak_sample_r,
  input wire [7:0] level, trial_word,
  output wire cmp_below
);
  reg [7:0] held_r;
  always @(posedge ref_clk) begin
    if (peak_clear_r) held_r <= 8'h00;
    else if (peak_sample_r && level > held_r) held_r <= level;
  end
  assign cmp_below = held_r < ~trial_word;
endmodule

//--- bench/sbp_servo_test.sv
`timescale 1ns/1ns
module sbp_servo_test;
  reg ref_clk = 1'b0, reset_n = 1'b0, fine_en = 1'b0, odd_track = 1'b0;
  reg [7:0] level = 8'h00;
  wire cmp_below, peak_clear_r, peak_sample_r, start_n, err_valid_r;
  wire [7:0] trial_word, burst_val_r, pos_err_r, drive_code_r;
  integer err_total = 0, tests_run = 0, cycles = 0;
  // clock
  always #5 ref_clk = ~ref_clk;
  sbp_servo sbp_servo_i (.ref_clk, .reset_n, .fine_en, .odd_track, .cmp_below, .peak_clear_r, .peak_sample_r,
    .start_n, .trial_word, .burst_val_r, .pos_err_r, .err_valid_r, .drive_code_r);
  sbp_peak_model sbp_peak_model_i (.ref_clk, .peak_clear_r, .peak_sample_r, .level, .trial_word, .cmp_below);
  task check(input [7:0] seen, want);
    begin
      tests_run = tests_run + 1;
      if (seen !== want) begin
        err_total = err_total + 1;
        $display("ERROR %0t %h %h", $time, seen, want);
      end
    end
  endtask
  task print_verdict;
    begin
      $display("%0d compares %0d errors", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  // hang guard
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      err_total = err_total + 1;
      print_verdict;
    end
  end
  task run_pair(input odd, input [7:0] b, a, e);
    begin
      @(posedge ref_clk);
      odd_track <= odd;
      level <= b;
      @(negedge start_n);
      @(posedge peak_clear_r);
      level <= a;
      @(posedge err_valid_r);
      #1 check(pos_err_r, e);
      check(drive_code_r, e ^ 8'h80);
      check(burst_val_r, a);
    end
  endtask
  task idle_drop;
    begin
      @(posedge ref_clk);
      fine_en <= 1'b0;
      @(posedge err_valid_r);
      repeat (2) @(posedge ref_clk);
      #1 check(drive_code_r, 8'h80);
      check({7'h00, peak_clear_r}, 8'h01);
    end
  endtask
  // odd track pair, then even track pair
  initial begin
    repeat (12) @(posedge ref_clk);
    reset_n <= 1'b1;
    fine_en <= 1'b1;
    run_pair(1'b1, 8'h30, 8'h10, 8'hf0); // 32*(16-48)/64
    run_pair(1'b0, 8'h30, 8'h10, 8'h10); // 32*(48-16)/64
    idle_drop;
    print_verdict;
  end
endmodule
